/* src/irs_defines.vh */
// Constants for the interrupt-enable and square-wave configuration block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef IRS_DEFINES_VH
`define IRS_DEFINES_VH

// Register indices; byte address is four times the index
`define IRS_IDX_IRQ_CFG 8'h12
`define IRS_IDX_SQW_CTL 8'h13
`define IRS_ADDR_IRQ_CFG 8'h48
`define IRS_ADDR_SQW_CTL 8'h4c

// Reset values
`define IRS_RST_IRQ_CFG 8'he0
`define IRS_RST_SQW_CTL 8'h26
`define IRS_RST_SQW_SEL 5'h06
`define IRS_SQW_RSVD 2'h1

// Interrupt enable/config field positions
`define IRS_CEB_BIT 7
`define IRS_MODE_HI 6
`define IRS_MODE_LO 5
`define IRS_BATTERY_LOW_IRQ_ENABLE_BIT 4
`define IRS_TIE_BIT 3
`define IRS_AIE_BIT 2
`define IRS_X2E_BIT 1
`define IRS_X1E_BIT 0

// Square wave control field positions
`define IRS_SQUARE_WAVE_ENABLE_BIT 7
`define IRS_SEL_HI 4
`define IRS_SEL_LO 0

// Flag vector positions
`define IRS_FLG_BL 4
`define IRS_FLG_TIM 3
`define IRS_FLG_ALM 2
`define IRS_FLG_X2 1
`define IRS_FLG_X1 0

// Interrupt pulse modes
`define IRS_MODE_LEVEL 2'h0
`define IRS_MODE_SHORT 2'h1
`define IRS_MODE_MID 2'h2
`define IRS_MODE_LONG 2'h3

// Pulse lengths in oscillator half-period ticks (XT 65536/s, RC 256/s)
`define IRS_XT_TICK_HZ 65536
`define IRS_RC_TICK_HZ 256
`define IRS_LEN_XT_8192 15'h0008
`define IRS_LEN_XT_64 15'h0400
`define IRS_LEN_XT_4 15'h4000
`define IRS_LEN_RC_64 15'h0004
`define IRS_LEN_RC_4 15'h0040

// Divider tap offset between XT and RC ticks (log2 of 65536/256)
`define IRS_RC_TAP_OFS 5'h08

// Square wave select codes
`define IRS_SEL_CENTURY 5'h00
`define IRS_SEL_F16K 5'h16
`define IRS_SEL_MINUTE 5'h15
`define IRS_SEL_LAST_DIV 5'h14
`define IRS_SEL_F100 5'h17
`define IRS_SEL_HOUR 5'h18
`define IRS_SEL_DAY 5'h19
`define IRS_SEL_TIMER_IRQ_SIGNAL 5'h1a
`define IRS_SEL_TIMER_IRQ_SIGNAL_N 5'h1b
`define IRS_SEL_YEAR 5'h1c
`define IRS_SEL_CNT1HZ 5'h1d
`define IRS_SEL_ACAL32 5'h1e
`define IRS_SEL_ACAL8 5'h1f

// Pin routing codes
`define IRS_ROUTE_IRQ 2'h0
`define IRS_ROUTE_SQW 2'h1
`define IRS_ROUTE_BOTH 2'h2
`define IRS_ROUTE_ALARM 2'h3

`endif

/* src/irs_sync.v */
// Two-flip-flop synchroniser for one asynchronous level.
// Assumes the input comes from a pin outside the clk domain.
`timescale 1ns/1ps
`default_nettype none
module irs_sync (
  input wire clk,
  input wire rst_n,
  input wire async_in,
  output wire sync_out
);
  reg meta_ff;
  reg sync_ff;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // irs_sync
`default_nettype wire

/* src/irs_pulse.v */
// Pulse-width timer: holds active for a given count of oscillator ticks.
// Assumes start, tick and clear are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
module irs_pulse (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire clear,
  input wire tick,
  input wire [14:0] len,
  output wire active
);
  reg [14:0] cnt_ff;
  reg act_ff;
  reg [14:0] nxt_cnt;
  reg nxt_act;

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_act = act_ff;
    if (clear) begin
      nxt_act = 1'b0;
      nxt_cnt = 15'h0000;
    end else if (start) begin
      nxt_act = 1'b1;
      nxt_cnt = len;
    end else if (act_ff && tick) begin
      if (cnt_ff <= 15'h0001) begin
        nxt_act = 1'b0;
        nxt_cnt = 15'h0000;
      end else begin
        nxt_cnt = cnt_ff - 15'h0001;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 15'h0000;
      act_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      act_ff <= nxt_act;
    end
  end

  assign active = act_ff;
endmodule // irs_pulse
`default_nettype wire

/* src/irs_top.v */
// Interrupt enable/mode and square wave select logic of a real-time clock.
// Assumes an APB master on clk, oscillator half-period ticks from the clock
// system, and event pulses from timer, alarm, battery and calendar logic.
// Behaviour
// RULE_01 - Century bit toggles on year wrap 99 to 00 only when enabled.
// RULE_02 - Pulse mode field bits 6:5; mode 00 gives level alarm output.
// RULE_03 - Mode 01: 1/8192 s on crystal, 1/64 s on RC oscillator.
// RULE_04 - Mode 10 gives 1/64 s; mode 11 gives 1/4 s in both.
// RULE_05 - Alarm output returns high as soon as its flag is cleared.
// RULE_06 - Software should keep pulse mode at 3 for lowest current.
// RULE_07 - Battery-low enable bit 4 gates battery-low interrupt.
// RULE_08 - Timer enable bit 3: timer zero sets timer flag, asserts request.
// RULE_09 - Alarm enable bit 2: full alarm match asserts the request.
// RULE_10 - Enable bit 1: chosen watchdog-pin edge raises second external interrupt.
// RULE_11 - Enable bit 0: chosen external-pin edge raises first external interrupt.
// RULE_12 - Square wave enable bit 7 drives wave, else static output level.
// RULE_13 - Select bits 4:0; 00001 32.768 kHz, then halving to 1/32 Hz.
// RULE_14 - Codes 10101..11111 give minute, 16k, 100 Hz, timer, tick, autocal.
// RULE_15 - Codes 00000, 11000, 11001, 11100 give century, hour, day, year pulses.
// RULE_16 - Software avoids high-rate selections while RC oscillator runs.
// RULE_17 - Select field resets to 00110, a 512 Hz output.
// RULE_18 - External flags set only while enabled; disabling keeps them.
// RULE_19 - Static output bit is the wave level while generation is off.
// RULE_20 - Default routing: active-low interrupt if any enabled, else static bit.
// RULE_21 - Waves divide the active oscillator, changing on the device clock.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "irs_defines.vh"
module irs_top (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  input wire rc_mode,
  input wire osc_half_tick,
  input wire year_wrap,
  input wire timer_zero,
  input wire alarm_match,
  input wire battery_low_event,
  input wire watchdog_input_pin,
  input wire external_input_pin,
  input wire first_edge_polarity,
  input wire second_edge_polarity,
  input wire [4:0] flag_clear,
  input wire static_out,
  input wire [1:0] freq_pin_route_select,
  input wire timer_irq_signal,
  input wire minute_wave,
  input wire hundred_hz_wave,
  input wire counter_1hz_tick,
  input wire acal32_pulse,
  input wire acal8_pulse,
  input wire century_pulse,
  input wire hour_pulse,
  input wire day_pulse,
  input wire year_pulse,
  output wire [4:0] irq_flags,
  output wire irq_out_n,
  output wire alarm_irq_out_n,
  output reg century_toggle_bit,
  output reg square_wave_out,
  output wire freq_irq_pin_out,
  output wire freq_irq_pin_oe
);
  // ***************************************************************
  // Register bus
  // ***************************************************************
  reg [7:0] irq_cfg_ff;
  reg square_wave_enable_ff;
  reg [4:0] sel_ff;
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  wire hit_cfg = (paddr == `IRS_ADDR_IRQ_CFG);
  wire hit_sqw = (paddr == `IRS_ADDR_SQW_CTL);

  // No wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_cfg && !hit_sqw;

  always @(posedge clk) begin
    if (!rst_n) begin
      irq_cfg_ff <= `IRS_RST_IRQ_CFG;
      square_wave_enable_ff <= 1'b0;
      // RULE_17 - select reset value
      sel_ff <= `IRS_RST_SQW_SEL;
    end else if (wr_en) begin
      if (hit_cfg) begin
        irq_cfg_ff <= pwdata[7:0];
      end
      if (hit_sqw) begin
        square_wave_enable_ff <= pwdata[`IRS_SQUARE_WAVE_ENABLE_BIT];
        sel_ff <= pwdata[`IRS_SEL_HI:`IRS_SEL_LO];
      end
    end
  end

  // Read data latched in the setup cycle so it is stable in the access cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      if (hit_cfg) begin
        prdata <= {24'h000000, irq_cfg_ff};
      end else if (hit_sqw) begin
        prdata <= {24'h000000, square_wave_enable_ff, `IRS_SQW_RSVD, sel_ff};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  wire ceb = irq_cfg_ff[`IRS_CEB_BIT];
  wire [1:0] pmode = irq_cfg_ff[`IRS_MODE_HI:`IRS_MODE_LO];
  wire battery_low_irq_enable = irq_cfg_ff[`IRS_BATTERY_LOW_IRQ_ENABLE_BIT];
  wire timer_irq_enable = irq_cfg_ff[`IRS_TIE_BIT];
  wire alarm_irq_enable = irq_cfg_ff[`IRS_AIE_BIT];
  wire x2e = irq_cfg_ff[`IRS_X2E_BIT];
  wire x1e = irq_cfg_ff[`IRS_X1E_BIT];

  // ***************************************************************
  // Century bit
  // ***************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      century_toggle_bit <= 1'b0;
    end else if (year_wrap && ceb) begin
      // RULE_01 - toggle on year wrap
      century_toggle_bit <= ~century_toggle_bit;
    end
  end

  // ***************************************************************
  // External pin edges
  // ***************************************************************
  wire wdi_s;
  wire external_input_pin_s;
  reg wdi_d_ff;
  reg external_input_pin_d_ff;

  irs_sync u_sync_wdi (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(watchdog_input_pin),
    .sync_out(wdi_s)
  );

  irs_sync u_sync_external_input_pin (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(external_input_pin),
    .sync_out(external_input_pin_s)
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      wdi_d_ff <= 1'b1;
      external_input_pin_d_ff <= 1'b1;
    end else begin
      wdi_d_ff <= wdi_s;
      external_input_pin_d_ff <= external_input_pin_s;
    end
  end

  // Polarity 1 selects rising edge, 0 falling edge
  wire second_edge = second_edge_polarity ? (wdi_s && !wdi_d_ff) : (!wdi_s && wdi_d_ff);
  wire first_edge = first_edge_polarity ? (external_input_pin_s && !external_input_pin_d_ff) : (!external_input_pin_s && external_input_pin_d_ff);

  // ***************************************************************
  // Interrupt flags
  // ***************************************************************
  reg [4:0] flag_ff;
  wire [4:0] flag_set;

  // RULE_07 - battery-low gated by enable
  assign flag_set[`IRS_FLG_BL] = battery_low_event && battery_low_irq_enable;
  // RULE_08 - timer zero sets timer flag
  assign flag_set[`IRS_FLG_TIM] = timer_zero && timer_irq_enable;
  // RULE_09 - alarm match gated by enable
  assign flag_set[`IRS_FLG_ALM] = alarm_match && alarm_irq_enable;
  // RULE_10 - watchdog pin edge
  assign flag_set[`IRS_FLG_X2] = second_edge && x2e;
  // RULE_11 - external pin edge
  assign flag_set[`IRS_FLG_X1] = first_edge && x1e;

  // RULE_18 - set only when enabled, disable keeps flag
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag
      always @(posedge clk) begin
        if (!rst_n) begin
          flag_ff[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flag_ff[gi] <= 1'b1;
        end else if (flag_clear[gi]) begin
          flag_ff[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_flags = flag_ff;
  // RULE_08 - request asserted while a flag stands
  assign irq_out_n = ~(|flag_ff);

  // ***************************************************************
  // Alarm interrupt output width
  // ***************************************************************
  reg [14:0] pulse_len;
  wire pulse_act;
  wire alm_start = flag_set[`IRS_FLG_ALM];
  wire alm_clear = flag_clear[`IRS_FLG_ALM] && !alm_start;

  // RULE_03 - short width depends on oscillator
  // RULE_04 - mid and long widths
  always @* begin
    case (pmode)
      `IRS_MODE_SHORT: pulse_len = rc_mode ? `IRS_LEN_RC_64 : `IRS_LEN_XT_8192;
      `IRS_MODE_MID: pulse_len = rc_mode ? `IRS_LEN_RC_64 : `IRS_LEN_XT_64;
      `IRS_MODE_LONG: pulse_len = rc_mode ? `IRS_LEN_RC_4 : `IRS_LEN_XT_4;
      default: pulse_len = 15'h0000;
    endcase
  end

  irs_pulse u_pulse (
    .clk(clk),
    .rst_n(rst_n),
    .start(alm_start),
    .clear(alm_clear),
    .tick(osc_half_tick),
    .len(pulse_len),
    .active(pulse_act)
  );

  // RULE_02 - level mode follows the flag
  // RULE_05 - released when the flag clears
  assign alarm_irq_out_n = ~(flag_ff[`IRS_FLG_ALM] &&
                             ((pmode == `IRS_MODE_LEVEL) || pulse_act));

  // ***************************************************************
  // Square wave generation
  // ***************************************************************
  // Counter of oscillator half periods; tap n runs at 32768/2^n Hz on XT
  reg [20:0] div_ff;
  reg [4:0] tap;
  reg tap_ok;
  reg nxt_sqw;

  always @(posedge clk) begin
    if (!rst_n) begin
      div_ff <= 21'h000000;
    end else if (osc_half_tick) begin
      // RULE_21 - divide active oscillator
      div_ff <= div_ff + 21'h000001;
    end
  end

  // RC ticks are 256 times slower, so its taps sit eight places lower
  always @* begin
    tap = 5'h00;
    tap_ok = 1'b0;
    if (sel_ff == `IRS_SEL_F16K) begin
      tap = 5'h01;
      tap_ok = !rc_mode;
    end else if (rc_mode) begin
      tap = sel_ff - `IRS_RC_TAP_OFS;
      tap_ok = (sel_ff >= `IRS_RC_TAP_OFS) && (sel_ff <= `IRS_SEL_LAST_DIV);
    end else begin
      // Code 1 is the full crystal rate on bit 0; bit 1 belongs to 16.384 kHz
      tap = (sel_ff == 5'h01) ? 5'h00 : sel_ff;
      tap_ok = (sel_ff != `IRS_SEL_CENTURY) && (sel_ff <= `IRS_SEL_LAST_DIV);
    end
  end

  // RULE_13 - divider taps
  // RULE_14 - special selections
  // RULE_15 - test pulses
  always @* begin
    case (sel_ff)
      `IRS_SEL_CENTURY: nxt_sqw = century_pulse;
      `IRS_SEL_MINUTE: nxt_sqw = minute_wave;
      `IRS_SEL_F100: nxt_sqw = hundred_hz_wave && !rc_mode;
      `IRS_SEL_HOUR: nxt_sqw = hour_pulse;
      `IRS_SEL_DAY: nxt_sqw = day_pulse;
      `IRS_SEL_TIMER_IRQ_SIGNAL: nxt_sqw = timer_irq_signal;
      `IRS_SEL_TIMER_IRQ_SIGNAL_N: nxt_sqw = !timer_irq_signal;
      `IRS_SEL_YEAR: nxt_sqw = year_pulse;
      `IRS_SEL_CNT1HZ: nxt_sqw = counter_1hz_tick;
      `IRS_SEL_ACAL32: nxt_sqw = acal32_pulse;
      `IRS_SEL_ACAL8: nxt_sqw = acal8_pulse;
      default: nxt_sqw = tap_ok && div_ff[tap];
    endcase
  end

  // RULE_12 - enable gates the wave
  // RULE_19 - static bit as idle level
  always @(posedge clk) begin
    if (!rst_n) begin
      square_wave_out <= 1'b0;
    end else begin
      square_wave_out <= square_wave_enable_ff ? nxt_sqw : static_out;
    end
  end

  // ***************************************************************
  // Frequency/interrupt pin routing
  // ***************************************************************
  wire any_en = battery_low_irq_enable || timer_irq_enable || alarm_irq_enable || x2e || x1e;
  reg pin_lvl;

  // RULE_20 - default routing
  always @* begin
    case (freq_pin_route_select)
      `IRS_ROUTE_IRQ: pin_lvl = any_en ? irq_out_n : static_out;
      `IRS_ROUTE_SQW: pin_lvl = square_wave_out;
      `IRS_ROUTE_BOTH: pin_lvl = square_wave_enable_ff ? square_wave_out :
                                 (any_en ? irq_out_n : static_out);
      `IRS_ROUTE_ALARM: pin_lvl = alarm_irq_enable ? alarm_irq_out_n : static_out;
      default: pin_lvl = static_out;
    endcase
  end

  // Open drain: only pulls low, the wire floats high otherwise
  assign freq_irq_pin_out = 1'b0;
  assign freq_irq_pin_oe = !pin_lvl;
endmodule // irs_top
`default_nettype wire

/* dv/irs_top_sva.sv */
// Checker for irs_top port behaviour, bound into every irs_top.
// Assumes APB writes take effect at the access edge, as the design does.
`timescale 1ns/1ps
`default_nettype none
module irs_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic year_wrap,
  input wire logic timer_zero,
  input wire logic battery_low_event,
  input wire logic [4:0] flag_clear,
  input wire logic static_out,
  input wire logic [1:0] freq_pin_route_select,
  input wire logic [4:0] irq_flags,
  input wire logic irq_out_n,
  input wire logic alarm_irq_out_n,
  input wire logic century_toggle_bit,
  input wire logic square_wave_out,
  input wire logic freq_irq_pin_oe
);
  // ****************************************
  // Shadow of configuration writes
  // ****************************************
  logic [7:0] cfg_ff;
  logic square_wave_enable_ff;
  wire wr = psel && penable && pwrite;
  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_ff <= 8'he0;
      square_wave_enable_ff <= 1'b0;
    end else begin
      if (wr && paddr == 8'h48) cfg_ff <= pwdata[7:0];
      if (wr && paddr == 8'h4c) square_wave_enable_ff <= pwdata[7];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_century_flip: assert property (
    year_wrap && cfg_ff[7] |=> century_toggle_bit != $past(century_toggle_bit))
    else $error("century bit missed a toggle");
  a_level_hold: assert property (
    cfg_ff[6:5] == 2'h0 && irq_flags[2] |-> !alarm_irq_out_n)
    else $error("level alarm output not low");
  a_alarm_release: assert property ($fell(irq_flags[2]) |-> alarm_irq_out_n)
    else $error("alarm output stuck low after clear");
  a_batt_gate: assert property (
    !irq_flags[4] && !(battery_low_event && cfg_ff[4]) |=> !irq_flags[4])
    else $error("battery flag set without enable");
  a_timer_set: assert property (
    timer_zero && cfg_ff[3] |=> irq_flags[3] && !irq_out_n)
    else $error("timer flag or request missing");
  a_ext_sticky: assert property (irq_flags[0] && !flag_clear[0] |=> irq_flags[0])
    else $error("external flag lost without clear");
  a_static_wave: assert property (
    !square_wave_enable_ff |=> square_wave_out == $past(static_out))
    else $error("wave output not static level");
  a_pin_route: assert property (freq_pin_route_select == 2'h0 |->
    freq_irq_pin_oe == ((|cfg_ff[4:0]) ? !irq_out_n : !static_out))
    else $error("pin level wrong for default route");
  c_year: cover property (year_wrap && cfg_ff[7]);
  c_timer: cover property (timer_zero && cfg_ff[3]);
  c_clear: cover property ($fell(irq_flags[2]));
endmodule // irs_chk

bind irs_top irs_chk i_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .year_wrap(year_wrap),
  .timer_zero(timer_zero), .battery_low_event(battery_low_event), .flag_clear(flag_clear),
  .static_out(static_out), .freq_pin_route_select(freq_pin_route_select),
  .irq_flags(irq_flags), .irq_out_n(irq_out_n), .alarm_irq_out_n(alarm_irq_out_n),
  .century_toggle_bit(century_toggle_bit), .square_wave_out(square_wave_out),
  .freq_irq_pin_oe(freq_irq_pin_oe));
`default_nettype wire

/* dv/test_irs_top.sv */
// Bench for irs_top: table of wave and pulse cases, then hand cases.
// Assumes a 10 MHz clock and the APB slave answering with no wait states.
`timescale 1ns/1ps
`default_nettype none
module test_irs_top;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic rc_mode = 1'b0, tick = 1'b0, stat = 1'b0, xpin = 1'b0, wpin = 1'b1;
  logic pol1 = 1'b1, pol2 = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [1:0] route = 2'h0, kind;
  logic [8:0] ev = 9'h0;
  logic [9:0] src = 10'h0;
  logic [4:0] code;
  logic [3:0] arg;
  logic [16:0] expv;
  wire pready, pslverr, irq_n, alarm_n, cbit, swo, pin_out, pin_oe;
  wire [31:0] prdata;
  wire [4:0] flags;
  int miscompares = 0, total_checks = 0, i, n;
  // ****************************************
  // Rows: kind 0 source, 1 wave ticks, 2 pulse ticks
  // ****************************************
  // pulse rows end in mode 3
  logic [27:0] rows [0:22] = '{{2'h0,5'h15,4'h0,17'h1}, {2'h0,5'h17,4'h1,17'h1},
    {2'h0,5'h1a,4'h2,17'h1}, {2'h0,5'h1b,4'h2,17'h0}, {2'h0,5'h1d,4'h3,17'h1},
    {2'h0,5'h1e,4'h4,17'h1}, {2'h0,5'h1f,4'h5,17'h1}, {2'h0,5'h00,4'h6,17'h1},
    {2'h0,5'h18,4'h7,17'h1}, {2'h0,5'h19,4'h8,17'h1}, {2'h0,5'h1c,4'h9,17'h1},
    {2'h1,5'h01,4'h0,17'h1}, {2'h1,5'h16,4'h0,17'h2},
    {2'h1,5'h02,4'h0,17'h4}, {2'h1,5'h06,4'h0,17'h40}, {2'h1,5'h08,4'h1,17'h1},
    {2'h1,5'h0c,4'h1,17'h10}, {2'h2,5'h01,4'h0,17'h8}, {2'h2,5'h01,4'h1,17'h4},
    {2'h2,5'h02,4'h0,17'h400}, {2'h2,5'h02,4'h1,17'h4}, {2'h2,5'h03,4'h1,17'h40},
    {2'h2,5'h03,4'h0,17'h4000}};
  irs_top i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .rc_mode(rc_mode), .osc_half_tick(tick), .year_wrap(ev[0]), .timer_zero(ev[1]),
    .alarm_match(ev[2]), .battery_low_event(ev[3]), .watchdog_input_pin(wpin),
    .external_input_pin(xpin), .first_edge_polarity(pol1), .second_edge_polarity(pol2),
    .flag_clear(ev[8:4]), .static_out(stat), .freq_pin_route_select(route),
    .timer_irq_signal(src[2]), .minute_wave(src[0]), .hundred_hz_wave(src[1]),
    .counter_1hz_tick(src[3]), .acal32_pulse(src[4]), .acal8_pulse(src[5]),
    .century_pulse(src[6]), .hour_pulse(src[7]), .day_pulse(src[8]), .year_pulse(src[9]),
    .irq_flags(flags), .irq_out_n(irq_n), .alarm_irq_out_n(alarm_n),
    .century_toggle_bit(cbit), .square_wave_out(swo), .freq_irq_pin_out(pin_out),
    .freq_irq_pin_oe(pin_oe));
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task hang();
    miscompares++;
    close_out();
  endtask
  // Entered right after a rising edge; one idle cycle follows each transfer
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task pulse(input logic [8:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 9'h0;
    @(posedge clk);
  endtask
  // First two changes only align to the wave; the third interval is counted
  task wave_ticks(output int cnt);
    logic last;
    int k;
    k = 0;
    repeat (3) begin
      last = swo;
      cnt = 0;
      while (swo === last) begin
        cnt += tick;
        k++;
        if (k > 3000) hang();
        @(posedge clk);
      end
    end
  endtask
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) tick <= !tick;
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 23; i++) begin
      {kind, code, arg, expv} = rows[i];
      rc_mode <= kind != 2'h0 && arg[0];
      if (kind == 2'h2) begin
        apb(1'b1, 8'h48, {25'h0, code[1:0], 5'h04});
        pulse(9'h004);
        for (n = 0; alarm_n === 1'b0; n += tick) begin
          if (n > 20000) hang();
          @(posedge clk);
        end
        chk("pulse_width", n + 1 >= expv && n <= expv + 1, 32'h1);
        pulse(9'h040);
      end else begin
        apb(1'b1, 8'h4c, {24'h0, 3'h4, code});
        if (kind == 2'h1) begin
          wave_ticks(n);
          chk("wave_ticks", n, expv);
        end else begin
          src <= 10'h1 << arg;
          repeat (3) @(posedge clk);
          chk("wave_source", swo, expv);
        end
      end
    end
    // ****************************************
    // Hand cases after a mid-run reset
    // ****************************************
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h4c, 32'h0);
    chk("sqw_reset", rd, 32'h26);
    apb(1'b1, 8'h4c, 32'hffffffff);
    apb(1'b0, 8'h4c, 32'h0);
    chk("sqw_readback", rd, 32'hbf);
    apb(1'b0, 8'h50, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    pulse(9'h001);
    chk("century_on", cbit, 32'h1);
    apb(1'b1, 8'h48, 32'h18);
    pulse(9'h001);
    chk("century_off", cbit, 32'h1);
    pulse(9'h004);
    pulse(9'h00a);
    chk("event_gate", {flags, irq_n, pin_oe}, 32'h61);
    pulse(9'h1f0);
    apb(1'b1, 8'h48, 32'h03);
    xpin <= 1'b1;
    wpin <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ext_edges", {flags, irq_n, pin_oe}, 32'h0d);
    apb(1'b1, 8'h48, 32'h00);
    chk("ext_sticky", flags, 32'h3);
    pulse(9'h030);
    xpin <= 1'b0;
    wpin <= 1'b1;
    repeat (4) @(posedge clk);
    xpin <= 1'b1;
    wpin <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ext_masked", {flags, pin_oe}, 32'h1);
    pol1 <= 1'b0;
    pol2 <= 1'b1;
    apb(1'b1, 8'h48, 32'h03);
    xpin <= 1'b0;
    wpin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("ext_polarity", flags, 32'h3);
    apb(1'b1, 8'h48, 32'h00);
    pulse(9'h030);
    apb(1'b1, 8'h4c, 32'h06);
    stat <= 1'b1;
    repeat (3) @(posedge clk);
    chk("static_wave", {swo, pin_oe}, 32'h2);
    chk("pin_drive", pin_out, 32'h0);
    apb(1'b1, 8'h48, 32'h04);
    pulse(9'h004);
    repeat (200) @(posedge clk);
    chk("level_hold", alarm_n, 32'h0);
    route <= 2'h1;
    @(posedge clk);
    chk("route_wave", pin_oe, 32'h0);
    route <= 2'h2;
    @(posedge clk);
    chk("route_both", pin_oe, 32'h1);
    route <= 2'h3;
    @(posedge clk);
    chk("route_alarm", pin_oe, 32'h1);
    route <= 2'h0;
    pulse(9'h040);
    chk("level_release", alarm_n, 32'h1);
    close_out();
  end
endmodule // test_irs_top
`default_nettype wire
